// >>> pkg/aioc_consts.svh
`ifndef AIOC_CONSTS_SVH
`define AIOC_CONSTS_SVH

// data port width and conversion length in converter clock cycles
`define AIOC_DATA_W        8
`define AIOC_CONV_CYCLES   8
// reset value of the dac registers
`define AIOC_DAC_RESET     8'h00
// msb position on the data port
`define AIOC_MSB           7
// midscale offset flipped to move between binary and twos complement
`define AIOC_SIGN_FLIP     8'h80
// interface modes
`define AIOC_MODE_ST       1'b0
`define AIOC_MODE_RD       1'b1

`endif

// >>> pkg/aioc_pkg.sv
package aioc_pkg;

   // host bus strobes, active low; dac_sel high selects the second dac register
   typedef struct packed {
      logic cs_n;
      logic rd_n;
      logic wr_n;
      logic dac_sel;
   } aioc_bus_type;

   // static analog and interface mode straps
   typedef struct packed {
      logic dual_supply;
      logic range_wide;
      logic rd_starts;
   } aioc_mode_type;

   typedef enum logic [1:0] {
      AIOC_IDLE = 2'b00,
      AIOC_WAIT = 2'b01,
      AIOC_CONV = 2'b10
   } aioc_state_type;

endpackage

// >>> src/aioc_sar.sv
`timescale 1ns/1ps
`include "aioc_consts.svh"

// successive approximation engine, steps on each converter clock enable
module aioc_sar #(
   parameter int WIDTH = `AIOC_DATA_W
) (
   input  wire logic             sys_clk,
   input  wire logic             rstn,
   input  wire logic             start,
   input  wire logic             step,
   input  wire logic             cmp_high,
   output logic                  done,
   output logic [WIDTH-1:0]      trial,
   output logic [WIDTH-1:0]      result
);

   // elaboration check: a single bit leaves no approximation to make
   if (WIDTH < 2)
   begin
      $error("aioc_sar: width too small");
   end

   logic [WIDTH-1:0] sar;
   logic [WIDTH-1:0] bitpos;
   logic [WIDTH-1:0] next_sar;
   logic [WIDTH-1:0] next_bitpos;
   logic [WIDTH-1:0] next_result;
   logic             next_done;

   assign trial = sar | bitpos;

   // keep the trial bit if the comparator says input is above it
   always_comb
   begin
      next_sar    = sar;
      next_bitpos = bitpos;
      next_result = result;
      next_done   = 1'b0;
      if (start)
      begin
         next_sar    = '0;
         next_bitpos = {1'b1, {(WIDTH-1){1'b0}}};
      end
      else if (step && bitpos != '0)
      begin
         next_sar    = cmp_high ? trial : sar;
         next_bitpos = bitpos >> 1;
         if (bitpos[0])
         begin
            next_result = cmp_high ? trial : sar;
            next_sar    = '0;
            next_done   = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         sar    <= '0;
         bitpos <= '0;
         result <= '0;
         done   <= 1'b0;
      end
      else
      begin
         sar    <= next_sar;
         bitpos <= next_bitpos;
         result <= next_result;
         done   <= next_done;
      end
   end

endmodule

// >>> src/aioc_ctrl.sv
`timescale 1ns/1ps
`include "aioc_consts.svh"

module aioc_ctrl #(
   parameter int WIDTH = `AIOC_DATA_W
) (
   input  wire logic                 sys_clk,
   input  wire logic                 rstn,
   input  wire logic                 reset_n,
   input  aioc_pkg::aioc_bus_type    bus,
   input  aioc_pkg::aioc_mode_type   mode,
   input  wire logic                 start_convert_n,
   input  wire logic                 conv_clk,
   input  wire logic                 cmp_high,
   input  wire logic [WIDTH-1:0]     data_port_in,
   output logic [WIDTH-1:0]          data_port_out,
   output logic                      data_port_oe,
   output logic                      busy_n,
   output logic                      int_n,
   output logic                      track_hold,
   output logic [WIDTH-1:0]          dac_trial,
   output logic [WIDTH-1:0]          first_dac_register,
   output logic [WIDTH-1:0]          second_dac_register,
   output logic [WIDTH-1:0]          first_dac_code,
   output logic [WIDTH-1:0]          second_dac_code,
   output logic                      range_wide,
   output logic                      bipolar
);

   // elaboration check: one sar bit per converter clock, so the port width is also the conversion length
   if (WIDTH != `AIOC_DATA_W || WIDTH != `AIOC_CONV_CYCLES)
   begin
      $error("aioc_ctrl: only an 8-bit port is served");
   end

   // flip msb to move between offset binary inside and twos complement outside
   function automatic logic [WIDTH-1:0] fmt(input logic [WIDTH-1:0] v, input logic dual);
      fmt = dual ? (v ^ `AIOC_SIGN_FLIP) : v;
   endfunction

   // edge helpers on a strobe and its previous-cycle sample
   function automatic logic fall_seen(input logic prev, input logic now);
      fall_seen = prev & ~now;
   endfunction

   function automatic logic rise_seen(input logic prev, input logic now);
      rise_seen = ~prev & now;
   endfunction

   aioc_pkg::aioc_state_type state;
   aioc_pkg::aioc_state_type next_state;
   logic             st_q;
   logic             rd_q;
   logic             cs_q;
   logic             wr_q;
   logic             clk_q;
   logic             next_int_n;
   logic             next_hold;
   logic [WIDTH-1:0] next_first;
   logic [WIDTH-1:0] next_second;
   logic [WIDTH-1:0] next_out;
   logic             start_ev;
   logic             clk_en;
   logic             sar_start;
   logic             sar_done;
   logic [WIDTH-1:0] sar_result;

   // previous-cycle strobe samples for edge detection
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         st_q  <= 1'b1;
         rd_q  <= 1'b1;
         cs_q  <= 1'b1;
         wr_q  <= 1'b1;
         clk_q <= 1'b0;
      end
      else
      begin
         st_q  <= start_convert_n;
         rd_q  <= bus.rd_n;
         cs_q  <= bus.cs_n;
         wr_q  <= bus.wr_n;
         clk_q <= conv_clk;
      end
   end

   // conv_clk is the external or rc-derived converter clock, sampled here
   assign clk_en = fall_seen(clk_q, conv_clk);
   assign start_ev = fall_seen(st_q, start_convert_n)
                   | (mode.rd_starts & ~bus.cs_n & fall_seen(rd_q, bus.rd_n));
   assign sar_start = (state == aioc_pkg::AIOC_IDLE) && start_ev;

   aioc_sar #(
      .WIDTH(WIDTH)
   ) u_sar (
      .sys_clk  (sys_clk),
      .rstn     (rstn),
      .start    (sar_start),
      .step     (clk_en && state == aioc_pkg::AIOC_CONV),
      .cmp_high (cmp_high),
      .done     (sar_done),
      .trial    (dac_trial),
      .result   (sar_result)
   );

   // conversion sequencer; reset_n is deliberately not used here
   always_comb
   begin
      next_state = state;
      next_hold  = track_hold;
      unique case (state)
         aioc_pkg::AIOC_IDLE:
            if (start_ev)
            begin
               next_state = aioc_pkg::AIOC_WAIT;
               next_hold  = 1'b1;
            end
         aioc_pkg::AIOC_WAIT:
            next_state = aioc_pkg::AIOC_CONV;  // busy falls after the hold
         aioc_pkg::AIOC_CONV:
            if (sar_done)
            begin
               next_state = aioc_pkg::AIOC_IDLE;
               next_hold  = 1'b0;
            end
         default:
            next_state = aioc_pkg::AIOC_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state      <= aioc_pkg::AIOC_IDLE;
         track_hold <= 1'b0;
      end
      else
      begin
         state      <= next_state;
         track_hold <= next_hold;
      end
   end

   assign busy_n = (state != aioc_pkg::AIOC_CONV);

   // interrupt and dac registers; completion wins over a same-cycle clear
   always_comb
   begin
      next_int_n  = int_n;
      next_first  = first_dac_register;
      next_second = second_dac_register;
      next_out    = data_port_out;
      if (rise_seen(cs_q, bus.cs_n) | rise_seen(rd_q, bus.rd_n))
         next_int_n = 1'b1;
      if (!reset_n)
      begin
         next_int_n  = 1'b1;
         next_first  = `AIOC_DAC_RESET;
         next_second = `AIOC_DAC_RESET;
      end
      if (sar_done)
      begin
         next_int_n = 1'b0;
         next_out   = fmt(sar_result, mode.dual_supply);
      end
      if (!bus.cs_n && rise_seen(wr_q, bus.wr_n) && reset_n)
      begin
         if (bus.dac_sel)
            next_second = data_port_in;
         else
            next_first = data_port_in;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         int_n               <= 1'b1;
         first_dac_register  <= `AIOC_DAC_RESET;
         second_dac_register <= `AIOC_DAC_RESET;
         data_port_out       <= '0;
      end
      else
      begin
         int_n               <= next_int_n;
         first_dac_register  <= next_first;
         second_dac_register <= next_second;
         data_port_out       <= next_out;
      end
   end

   assign data_port_oe = ~bus.cs_n & ~bus.rd_n;
   // dac codes in internal offset binary, same mode for both dacs
   assign first_dac_code  = fmt(first_dac_register, mode.dual_supply);
   assign second_dac_code = fmt(second_dac_register, mode.dual_supply);
   assign range_wide = mode.range_wide;
   assign bipolar    = mode.dual_supply;

endmodule

// >>> test/aioc_analog.sv
`timescale 1ns/1ps
// analog side: free running converter clock and held-input comparator
module aioc_analog (
   input  wire logic       sys_clk,
   input  wire logic [7:0] vin,
   input  wire logic [7:0] dac_trial,
   output logic            conv_clk,
   output logic            cmp_high
);
   logic [1:0] div = 2'h0;
   // a quarter of the system rate so every level spans two sampling edges
   always @(negedge sys_clk) div <= div + 2'h1;
   assign conv_clk = div[1];
   // keep the trial bit while the held input reaches it
   assign cmp_high = (vin >= dac_trial);
endmodule

// >>> test/aioc_ctrl_checker.sv
`timescale 1ns/1ps
// bus side checks of the converter control
module aioc_ctrl_checker #(
   parameter int WIDTH = 8
) (
   input wire logic               sys_clk,
   input wire logic               rstn,
   input wire logic               reset_n,
   input aioc_pkg::aioc_bus_type  bus,
   input aioc_pkg::aioc_mode_type mode,
   input wire logic               start_convert_n,
   input wire logic [WIDTH-1:0]   data_port_in,
   input wire logic               data_port_oe,
   input wire logic               busy_n,
   input wire logic               int_n,
   input wire logic               track_hold,
   input wire logic [WIDTH-1:0]   first_dac_register,
   input wire logic [WIDTH-1:0]   second_dac_register
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   // starts count only from idle, a start while busy is dropped
   a_oe_read: assert property (data_port_oe == (!bus.cs_n && !bus.rd_n))
      else $error("bad oe");
   a_start_edge: assert property ($fell(start_convert_n) && busy_n && !track_hold |-> ##1 track_hold ##1 !busy_n)
      else $error("bad start");
   a_rd_start: assert property (mode.rd_starts && !bus.cs_n && $fell(bus.rd_n) && busy_n && !track_hold |-> ##2 !busy_n)
      else $error("bad rd start");
   a_busy_len: assert property ($fell(busy_n) |-> (!busy_n)[*8] ##[1:1000] busy_n)
      else $error("bad busy");
   a_done_int: assert property ($rose(busy_n) |-> !int_n && !track_hold)
      else $error("bad done");
   a_int_clear: assert property (($rose(bus.rd_n) || $rose(bus.cs_n)) && busy_n |=> int_n)
      else $error("bad int clear");
   a_reset_dac: assert property (!reset_n && busy_n |=> int_n && first_dac_register == 8'h00 && second_dac_register == 8'h00)
      else $error("bad reset");
   a_dac_write: assert property (!bus.cs_n && $rose(bus.wr_n) && reset_n |=>
      ($past(bus.dac_sel) ? second_dac_register : first_dac_register) == $past(data_port_in))
      else $error("bad write");
endmodule
bind aioc_ctrl aioc_ctrl_checker #(.WIDTH(WIDTH)) i_chk (.sys_clk, .rstn, .reset_n, .bus, .mode, .start_convert_n,
   .data_port_in, .data_port_oe, .busy_n, .int_n, .track_hold, .first_dac_register, .second_dac_register);

// >>> test/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic                    sys_clk, rstn, reset_n, start_convert_n, conv_clk, cmp_high, oe, busy_n, int_n, rng, bip;
   logic [7:0]              vin, din, dout, trial, reg_a, reg_b, code_a, code_b;
   aioc_pkg::aioc_bus_type  bus;
   aioc_pkg::aioc_mode_type mode;
   int                      error_cnt, n_checks, k;
   typedef struct packed {logic sel; logic dual; logic [7:0] d; logic [7:0] v; logic [7:0] q; logic [7:0] c;} aioc_row_type;
   // dac select, supply mode, write data, held input, expected read code, expected dac code
   aioc_row_type rows [4] = '{'{1'h0, 1'h0, 8'h00, 8'h00, 8'h00, 8'h00}, '{1'h1, 1'h0, 8'hff, 8'hff, 8'hff, 8'hff},
                              '{1'h0, 1'h1, 8'ha5, 8'h81, 8'h01, 8'h25}, '{1'h1, 1'h1, 8'h3c, 8'h7f, 8'hff, 8'hbc}};
   aioc_ctrl i_dut (.sys_clk, .rstn, .reset_n, .bus, .mode, .start_convert_n, .conv_clk, .cmp_high,
      .data_port_in(din), .data_port_out(dout), .data_port_oe(oe), .busy_n, .int_n, .track_hold(),
      .dac_trial(trial), .first_dac_register(reg_a), .second_dac_register(reg_b), .first_dac_code(code_a),
      .second_dac_code(code_b), .range_wide(rng), .bipolar(bip));
   aioc_analog i_ana (.sys_clk, .vin, .dac_trial(trial), .conv_clk, .cmp_high);
   // 25 MHz system clock
   initial
   begin
      sys_clk = 1'h0;
      forever #20 sys_clk = ~sys_clk;
   end
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      n_checks++;
      if (s !== e)
      begin
         error_cnt++;
         $display("FAIL %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // bounded wait, a hang ends the run
   task automatic wait_busy(input logic lvl);
      for (int i = 0; i < 300 && busy_n !== lvl; i++)
         @(negedge sys_clk);
      chk("busy", {7'h0, lvl}, {7'h0, busy_n});
      if (busy_n !== lvl)
         end_sim();
   endtask
   // chip select stays low past the rising write strobe
   task automatic wr(input logic s, input logic [7:0] d, input logic c);
      bus.cs_n = c;
      bus.dac_sel = s;
      din = d;
      bus.wr_n = 1'h0;
      @(negedge sys_clk);
      bus.wr_n = 1'h1;
      @(negedge sys_clk);
      bus.cs_n = 1'h1;
      @(negedge sys_clk);
   endtask
   // start pin with the chip deselected, or a one-cycle selected read
   task automatic start(input logic by_rd);
      mode.rd_starts = by_rd;
      bus.cs_n = !by_rd;
      bus.rd_n = !by_rd;
      start_convert_n = by_rd;
      @(negedge sys_clk);
      start_convert_n = 1'h1;
      bus.rd_n = 1'h1;
      bus.cs_n = 1'h1;
      mode.rd_starts = 1'h0;
      wait_busy(1'h0);
   endtask
   task automatic conv(input logic by_rd, input logic [7:0] q);
      start(by_rd);
      wait_busy(1'h1);
      chk("int", 8'h00, {7'h0, int_n});
      bus.cs_n = 1'h0;
      bus.rd_n = 1'h0;
      @(negedge sys_clk);
      chk("oe", 8'h01, {7'h0, oe});
      chk("data", q, dout);
      bus.rd_n = 1'h1;
      bus.cs_n = 1'h1;
      repeat (2) @(negedge sys_clk);
      chk("int clr", 8'h01, {7'h0, int_n});
   endtask
   initial
   begin
      rstn = 1'h0;
      reset_n = 1'h1;
      start_convert_n = 1'h1;
      bus = 4'hf;
      mode = 3'h0;
      vin = 8'h00;
      din = 8'h00;
      repeat (8) @(negedge sys_clk);
      rstn = 1'h1;
      chk("rst int", 8'h01, {7'h0, int_n});
      for (k = 0; k < 4; k++)
      begin
         mode = {rows[k].dual, k[0], 1'h0};
         wr(rows[k].sel, rows[k].d, 1'h0);
         chk("dac", rows[k].d, rows[k].sel ? reg_b : reg_a);
         chk("code", rows[k].c, rows[k].sel ? code_b : code_a);
         chk("range", {7'h0, k[0]}, {7'h0, rng});
         chk("bipolar", {7'h0, rows[k].dual}, {7'h0, bip});
         vin = rows[k].v;
         conv(1'h0, rows[k].q);
      end
      // deselected write is ignored, then a read strobe start
      wr(1'h0, 8'h5a, 1'h1);
      chk("desel", 8'ha5, reg_a);
      vin = 8'h40;
      conv(1'h1, 8'hc0);
      // device reset mid conversion clears the dacs, conversion runs on
      vin = 8'h2b;
      start(1'h0);
      reset_n = 1'h0;
      @(negedge sys_clk);
      reset_n = 1'h1;
      chk("rst a", 8'h00, reg_a);
      chk("rst b", 8'h00, reg_b);
      wait_busy(1'h1);
      chk("int", 8'h00, {7'h0, int_n});
      chk("data", 8'hab, dout);
      reset_n = 1'h0;
      @(negedge sys_clk);
      reset_n = 1'h1;
      chk("rst int", 8'h01, {7'h0, int_n});
      end_sim();
   end
endmodule
